// ===== pei_phy_event_irq_unit.sv
// pei_phy_event_irq_unit: event mask, clear-on-read cause flags and the
// active-low management interrupt of the phy.
// assumes event pulses and mode levels synchronous to clk_sys, and a
// register master that holds each strobe for exactly one cycle.
//
// Contract
// - pin enable lets pending drive interrupt
// - interrupt low only when enable and pending
// - causes still set with pin disabled
// - pending while unread cause, cleared by read
// - no pending report without pin enable
// - speed change sets gated cause fourteen
// - cause thirteen energy or link by mode
// - mask thirteen follows low power mode
// - duplex change sets gated cause twelve
// - negotiation error sets gated cause eleven
// - negotiation done sets gated cause ten
// - next page sets gated cause nine
// - symbol error at 100/1000 sets cause eight
// - lock lost sets gated cause seven
// - crossover change sets gated cause six
// - crossover cause only with negotiation enabled
// - polarity change sets gated cause five
// - jabber cause only at 10 Mb/s
// - false carrier sets gated cause three
// - parallel detect error sets cause two
// - master/slave error only at 1000 Mb/s
// - receive error always sets cause zero
// - software sets low power, activity clears
// - sticky mask bits survive soft reset if held
`timescale 1ns/1ps

module pei_phy_event_irq_unit (
  input wire logic clk_sys,
  input wire logic srst,
  input wire pei_pkg::pei_bus_req_s busReq,
  output pei_pkg::pei_word_t rdData,
  input wire pei_pkg::pei_evt_s evt,
  input wire logic mgmtSoftRst,
  output logic mgmtIrqOutN
);
  import pei_pkg::*;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic busHit(
    input pei_bus_req_s r,
    input pei_addr_t a,
    input logic isWr
  );
    busHit = (isWr ? r.wr : r.rd) && (r.addr == a);
  endfunction

  // raw event vector before the mask; mode qualifiers applied here
  function automatic pei_word_t qualify(
    input pei_evt_s e,
    input logic lowPwr
  );
    pei_word_t q;
    q = '0;
    q[BIT_SPEED] = e.speedChg;
    q[BIT_LINK] = lowPwr ? e.energyDet : e.linkChg;
    q[BIT_DUPLEX] = e.duplexChg;
    q[BIT_AN_ERR] = e.anErr;
    q[BIT_AN_DONE] = e.anDone;
    q[BIT_PAGE] = e.pageRx;
    q[BIT_SYMBOL] = e.symErr && (e.speed != SPD_10);
    q[BIT_LOCK] = e.lockLost;
    q[BIT_XOVER] = e.xoverChg && e.anEnabled;
    q[BIT_POLARITY] = e.polarityChg;
    q[BIT_JABBER] = e.jabber && (e.speed == SPD_10);
    q[BIT_FALSE_CAR] = e.falseCarrier;
    q[BIT_PDET] = e.pdetErr;
    q[BIT_MS_ERR] = e.msErr && (e.speed == SPD_1000);
    q[BIT_RX_ERR] = e.rxErr;
    qualify = q;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  pei_word_t mask_r;
  pei_word_t cause_r;
  pei_word_t cause_nxt;
  pei_word_t rdData_r;
  pei_word_t rawEvt;
  pei_word_t setVec;
  logic lowPwr_r;
  logic stickyHold_r;
  logic irqN_r;
  logic pending;
  logic wrMask;
  logic wrExt;
  logic wrAux;
  logic rdCause;

  assign wrMask = busHit(busReq, ADDR_MASK, 1'b1);
  assign wrExt = busHit(busReq, ADDR_EXT_CTRL, 1'b1);
  assign wrAux = busHit(busReq, ADDR_AUX_CTRL, 1'b1);
  assign rdCause = busHit(busReq, ADDR_CAUSE, 1'b0);

  // ------------------------------------------------------------
  // event qualification
  // ------------------------------------------------------------
  // one mask bit serves both link change and energy detect
  assign rawEvt = qualify(evt, lowPwr_r);

  // mask gates every cause except the receive error one
  assign setVec = rawEvt & (mask_r | UNGATED_BITS) & CAUSE_EVT_BITS;

  // ------------------------------------------------------------
  // cause flags
  // ------------------------------------------------------------
  // set is or-ed after the read clear, so a same-cycle event survives
  always_comb begin
    cause_nxt = (rdCause ? CAUSE_RST : cause_r) | setVec;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cause_r <= CAUSE_RST;
    end else begin
      // causes keep collecting whatever the pin enable says
      cause_r <= cause_nxt;
    end
  end

  // summary bit is derived, so it can never outlive the pin enable
  assign pending = mask_r[BIT_PIN_EN] && (|cause_r[BIT_PEND-1:0]);

  // ------------------------------------------------------------
  // mask register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mask_r <= MASK_RST;
    end else if (mgmtSoftRst) begin
      if (stickyHold_r) begin
        mask_r <= (mask_r & STICKY_MASK_BITS) | (MASK_RST & ~STICKY_MASK_BITS);
      end else begin
        mask_r <= MASK_RST;
      end
    end else if (wrMask) begin
      mask_r <= busReq.wdata;
    end
  end

  // ------------------------------------------------------------
  // control bits
  // ------------------------------------------------------------
  // network activity wins over a write: the mode would be left at once
  always_ff @(posedge clk_sys) begin
    if (srst || mgmtSoftRst) begin
      lowPwr_r <= LOW_PWR_RST;
    end else if (evt.netActivity) begin
      lowPwr_r <= 1'b0;
    end else if (wrExt) begin
      lowPwr_r <= busReq.wdata[BIT_LOW_PWR];
    end
  end

  // the hold bit is itself sticky and so ignores the soft reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stickyHold_r <= STICKY_HOLD_RST;
    end else if (wrAux) begin
      stickyHold_r <= busReq.wdata[BIT_STICKY_HOLD];
    end
  end

  // ------------------------------------------------------------
  // interrupt pin
  // ------------------------------------------------------------
  // registered nand of enable and pending, one cycle behind the flags
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irqN_r <= 1'b1;
    end else begin
      irqN_r <= ~(mask_r[BIT_PIN_EN] & pending);
    end
  end

  assign mgmtIrqOutN = irqN_r;

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (srst || !busReq.rd) begin
      rdData_r <= '0;
    end else begin
      case (busReq.addr)
        ADDR_EXT_CTRL: begin
          rdData_r <= pei_word_t'(lowPwr_r) << BIT_LOW_PWR;
        end
        ADDR_MASK: begin
          rdData_r <= mask_r;
        end
        ADDR_CAUSE: begin
          rdData_r <= {pending, cause_r[BIT_PEND-1:0]};
        end
        ADDR_AUX_CTRL: begin
          rdData_r <= pei_word_t'(stickyHold_r) << BIT_STICKY_HOLD;
        end
        default: begin
          rdData_r <= '0;
        end
      endcase
    end
  end

  assign rdData = rdData_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_PIN_NAND: assert property (
    @(posedge clk_sys) disable iff (srst)
    !$past(srst) |->
    (mgmtIrqOutN == !($past(mask_r[BIT_PIN_EN]) && $past(|cause_r[14:0]))))
    else $error("interrupt pin not the nand of enable and pending");

  AST_PIN_DISABLED_HIGH: assert property (
    @(posedge clk_sys) disable iff (srst)
    (!mask_r[BIT_PIN_EN] && !$past(srst)) |=> mgmtIrqOutN)
    else $error("interrupt pin driven while pin enable is zero");

  AST_NO_PEND_WITHOUT_EN: assert property (
    @(posedge clk_sys) disable iff (srst)
    (busReq.rd && busReq.addr == ADDR_CAUSE && !mask_r[BIT_PIN_EN])
    |=> !rdData[BIT_PEND])
    else $error("pending reported with pin enable clear");

  AST_CAUSE_WHILE_PIN_OFF: assert property (
    @(posedge clk_sys) disable iff (srst)
    (!mask_r[BIT_PIN_EN] && mask_r[BIT_LOCK] && evt.lockLost && !mgmtSoftRst)
    |=> cause_r[BIT_LOCK])
    else $error("cause not set while pin enable is zero");

  AST_READ_CLEARS: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rdCause && setVec == '0) |=> (cause_r == '0) ##1 mgmtIrqOutN)
    else $error("cause read did not clear flags and pending");

  AST_READ_RETURNS_FLAGS: assert property (
    @(posedge clk_sys) disable iff (srst)
    rdCause |=> (rdData[14:0] == $past(cause_r[14:0])))
    else $error("cause read data differ from flags before clear");

  AST_SPEED_GATED: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_SPEED]) |-> ($past(mask_r[BIT_SPEED]) && $past(evt.speedChg)))
    else $error("speed cause set without mask or event");

  AST_LINK_BY_MODE: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_LINK]) |->
    ($past(mask_r[BIT_LINK]) &&
     ($past(lowPwr_r) ? $past(evt.energyDet) : $past(evt.linkChg))))
    else $error("link or energy cause set by the wrong source");

  AST_ENERGY_SETS: assert property (
    @(posedge clk_sys) disable iff (srst)
    (lowPwr_r && mask_r[BIT_LINK] && evt.energyDet) |=> cause_r[BIT_LINK])
    else $error("energy detect lost in low power mode");

  AST_XOVER_AN_ONLY: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_XOVER]) |-> $past(evt.anEnabled))
    else $error("crossover cause set with negotiation disabled");

  AST_JABBER_10_ONLY: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_JABBER]) |-> ($past(evt.speed) == SPD_10))
    else $error("jabber cause set outside 10 Mb/s");

  AST_MS_1000_ONLY: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_MS_ERR]) |-> ($past(evt.speed) == SPD_1000))
    else $error("master/slave cause set outside 1000 Mb/s");

  AST_SYMBOL_NOT_10: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_SYMBOL]) |-> ($past(evt.speed) != SPD_10))
    else $error("symbol cause set at 10 Mb/s");

  AST_RXERR_UNGATED: assert property (
    @(posedge clk_sys) disable iff (srst)
    evt.rxErr |=> cause_r[BIT_RX_ERR])
    else $error("receive error not recorded");

  AST_EVENT_DURING_READ: assert property (
    @(posedge clk_sys) disable iff (srst)
    (rdCause && evt.rxErr) |=> cause_r[BIT_RX_ERR] ##1
    (!$past(rdCause) || rdData[BIT_RX_ERR]))
    else $error("event in read cycle was lost");

  AST_LOW_PWR_CLEARED: assert property (
    @(posedge clk_sys) disable iff (srst)
    evt.netActivity |=> !lowPwr_r)
    else $error("low power mode survived network activity");

  AST_SOFT_RST_CLEARS: assert property (
    @(posedge clk_sys) disable iff (srst)
    (mgmtSoftRst && !stickyHold_r) |=> (mask_r == MASK_RST))
    else $error("mask kept over soft reset without sticky hold");

  AST_SOFT_RST_HOLDS: assert property (
    @(posedge clk_sys) disable iff (srst)
    (mgmtSoftRst && stickyHold_r) |=>
    (mask_r[14:0] == $past(mask_r[14:0])) && !mask_r[BIT_PIN_EN])
    else $error("sticky mask bits lost over held soft reset");

  AST_DUPLEX_GATED: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_DUPLEX]) |-> ($past(mask_r[BIT_DUPLEX]) && $past(evt.duplexChg)))
    else $error("duplex cause set without mask or event");

  AST_AN_ERR_GATED: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_AN_ERR]) |-> ($past(mask_r[BIT_AN_ERR]) && $past(evt.anErr)))
    else $error("negotiation error cause set without mask or event");

  AST_AN_DONE_GATED: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_AN_DONE]) |-> ($past(mask_r[BIT_AN_DONE]) && $past(evt.anDone)))
    else $error("negotiation done cause set without mask or event");

  AST_PAGE_GATED: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_PAGE]) |-> ($past(mask_r[BIT_PAGE]) && $past(evt.pageRx)))
    else $error("page cause set without mask or event");

  AST_LOCK_GATED: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_LOCK]) |-> ($past(mask_r[BIT_LOCK]) && $past(evt.lockLost)))
    else $error("lock lost cause set without mask or event");

  AST_XOVER_GATED: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_XOVER]) |-> ($past(mask_r[BIT_XOVER]) && $past(evt.xoverChg)))
    else $error("crossover cause set without mask or event");

  AST_POLARITY_GATED: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_POLARITY]) |-> ($past(mask_r[BIT_POLARITY]) && $past(evt.polarityChg)))
    else $error("polarity cause set without mask or event");

  AST_FALSE_CAR_GATED: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_FALSE_CAR]) |-> ($past(mask_r[BIT_FALSE_CAR]) && $past(evt.falseCarrier)))
    else $error("false carrier cause set without mask or event");

  AST_PDET_GATED: assert property (
    @(posedge clk_sys) disable iff (srst)
    $rose(cause_r[BIT_PDET]) |-> ($past(mask_r[BIT_PDET]) && $past(evt.pdetErr)))
    else $error("parallel detect cause set without mask or event");

  AST_FLAGS_HOLD: assert property (
    @(posedge clk_sys) disable iff (srst)
    (!rdCause && setVec == '0) |=> (cause_r == $past(cause_r)))
    else $error("cause flags changed without read or event");

  AST_RDDATA_IDLE: assert property (
    @(posedge clk_sys) disable iff (srst)
    !busReq.rd |=> (rdData == '0))
    else $error("read data present without a read");

  AST_SOFT_RST_LOW_PWR: assert property (
    @(posedge clk_sys) disable iff (srst)
    mgmtSoftRst |=> !lowPwr_r)
    else $error("low power mode survived soft reset");

  AST_MASK_WRITE: assert property (
    @(posedge clk_sys) disable iff (srst)
    (wrMask && !mgmtSoftRst) |=> (mask_r == $past(busReq.wdata)))
    else $error("mask write not taken");

endmodule

// ===== pei_pkg.sv
// pei_pkg: constants, register map and carriers of the phy event interrupt unit.
// assumes a 5-bit management register address space and 16-bit register data.
package pei_pkg;

  // ------------------------------------------------------------
  // widths and register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  typedef logic [DATA_W-1:0] pei_word_t;
  typedef logic [ADDR_W-1:0] pei_addr_t;

  localparam pei_addr_t ADDR_EXT_CTRL = 5'h17;
  localparam pei_addr_t ADDR_MASK = 5'h19;
  localparam pei_addr_t ADDR_CAUSE = 5'h1a;
  localparam pei_addr_t ADDR_AUX_CTRL = 5'h1c;

  localparam pei_word_t MASK_RST = 16'h0000;
  localparam pei_word_t CAUSE_RST = 16'h0000;
  localparam logic LOW_PWR_RST = 1'b0;
  localparam logic STICKY_HOLD_RST = 1'b0;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_LOW_PWR = 5;
  localparam int BIT_STICKY_HOLD = 1;
  localparam int BIT_PIN_EN = 15;
  localparam int BIT_PEND = 15;
  localparam int BIT_SPEED = 14;
  localparam int BIT_LINK = 13;
  localparam int BIT_DUPLEX = 12;
  localparam int BIT_AN_ERR = 11;
  localparam int BIT_AN_DONE = 10;
  localparam int BIT_PAGE = 9;
  localparam int BIT_SYMBOL = 8;
  localparam int BIT_LOCK = 7;
  localparam int BIT_XOVER = 6;
  localparam int BIT_POLARITY = 5;
  localparam int BIT_JABBER = 4;
  localparam int BIT_FALSE_CAR = 3;
  localparam int BIT_PDET = 2;
  localparam int BIT_MS_ERR = 1;
  localparam int BIT_RX_ERR = 0;

  // cause bits that events may set, and those set regardless of the mask
  localparam pei_word_t CAUSE_EVT_BITS = 16'h7fff;
  localparam pei_word_t UNGATED_BITS = 16'h0001;
  // mask bits kept over a soft reset when sticky hold is set
  localparam pei_word_t STICKY_MASK_BITS = 16'h7fff;

  // operating speed codes
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    pei_addr_t addr;
    pei_word_t wdata;
  } pei_bus_req_s;

  typedef struct packed {
    logic speedChg;
    logic linkChg;
    logic energyDet;
    logic duplexChg;
    logic anErr;
    logic anDone;
    logic pageRx;
    logic symErr;
    logic lockLost;
    logic xoverChg;
    logic polarityChg;
    logic jabber;
    logic falseCarrier;
    logic pdetErr;
    logic msErr;
    logic rxErr;
    logic netActivity;
    logic anEnabled;
    logic [1:0] speed;
  } pei_evt_s;

endpackage

// ===== pei_mgmt_master.sv
// pei_mgmt_master: station manager model driving the management register port.
// assumes each task is entered just after a rising edge and returns just after one.
`timescale 1ns/1ps

module pei_mgmt_master (
  input wire logic clk_sys,
  output pei_pkg::pei_bus_req_s busReq,
  input wire pei_pkg::pei_word_t rdData
);
  import pei_pkg::*;

  initial busReq = '0;

  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  // a trailing idle edge keeps two tasks from writing busReq in one step
  task automatic wr(input pei_addr_t a, input pei_word_t d);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    busReq <= '0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input pei_addr_t a, output pei_word_t d);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    busReq <= '0;
    @(posedge clk_sys);
    d = rdData;
  endtask

  // only software turns low power on; the phy turns it off
  task automatic setLowPower();
    wr(ADDR_EXT_CTRL, pei_word_t'(1) << BIT_LOW_PWR);
  endtask
endmodule

// ===== testbench.sv
// testbench: directed scenarios for the phy event interrupt unit.
// assumes the design checks its own port relations with in-file assertions.
`timescale 1ns/1ps

module testbench;
  import pei_pkg::*;

  logic clk_sys;
  logic srst;
  logic mgmtSoftRst;
  logic mgmtIrqOutN;
  pei_bus_req_s busReq;
  pei_word_t rdData;
  pei_evt_s evt;
  int fail_count;
  int checks;

  pei_phy_event_irq_unit pei_phy_event_irq_unit_i (.clk_sys(clk_sys), .srst(srst),
    .busReq(busReq), .rdData(rdData), .evt(evt), .mgmtSoftRst(mgmtSoftRst),
    .mgmtIrqOutN(mgmtIrqOutN));
  pei_mgmt_master pei_mgmt_master_i (.clk_sys(clk_sys), .busReq(busReq), .rdData(rdData));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic end_sim();
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input pei_word_t got, input pei_word_t exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input pei_addr_t a, input pei_word_t exp);
    pei_word_t d;
    pei_mgmt_master_i.rd(a, d);
    chk(d, exp);
  endtask

  // pin settles one cycle after its cause; realign to the edge afterwards
  task automatic chkIrq(input logic exp);
    #1;
    chk({15'h0000, mgmtIrqOutN}, {15'h0000, exp});
    @(posedge clk_sys);
  endtask

  // index 16 is energy detect, 17 network activity
  task automatic setEvt(input int b, input logic v);
    case (b)
      BIT_SPEED: evt.speedChg <= v;
      BIT_LINK: evt.linkChg <= v;
      BIT_DUPLEX: evt.duplexChg <= v;
      BIT_AN_ERR: evt.anErr <= v;
      BIT_AN_DONE: evt.anDone <= v;
      BIT_PAGE: evt.pageRx <= v;
      BIT_SYMBOL: evt.symErr <= v;
      BIT_LOCK: evt.lockLost <= v;
      BIT_XOVER: evt.xoverChg <= v;
      BIT_POLARITY: evt.polarityChg <= v;
      BIT_JABBER: evt.jabber <= v;
      BIT_FALSE_CAR: evt.falseCarrier <= v;
      BIT_PDET: evt.pdetErr <= v;
      BIT_MS_ERR: evt.msErr <= v;
      BIT_RX_ERR: evt.rxErr <= v;
      16: evt.energyDet <= v;
      default: evt.netActivity <= v;
    endcase
  endtask

  task automatic pulse(input int b);
    setEvt(b, 1'b1);
    @(posedge clk_sys);
    setEvt(b, 1'b0);
    @(posedge clk_sys);
  endtask

  task automatic softReset();
    mgmtSoftRst <= 1'b1;
    @(posedge clk_sys);
    mgmtSoftRst <= 1'b0;
    @(posedge clk_sys);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic scResetAndMap();
    rdchk(ADDR_MASK, MASK_RST);
    rdchk(ADDR_CAUSE, CAUSE_RST);
    pei_mgmt_master_i.wr(ADDR_CAUSE, 16'hffff);
    rdchk(ADDR_CAUSE, 16'h0000);
    pei_mgmt_master_i.wr(5'h1f, 16'hffff);
    rdchk(5'h1f, 16'h0000);
    chkIrq(1'b1);
  endtask

  // each gated event sets only its own bit, and only through its own mask bit
  task automatic scGatedEvents();
    pei_word_t one;
    for (int b = 1; b < 15; b++) begin
      one = pei_word_t'(1) << b;
      evt.speed <= (b == BIT_JABBER) ? SPD_10 : SPD_1000;
      pei_mgmt_master_i.wr(ADDR_MASK, 16'h8000 | one);
      pulse(b);
      rdchk(ADDR_CAUSE, 16'h8000 | one);
      pei_mgmt_master_i.wr(ADDR_MASK, 16'hfffe ^ one);
      pulse(b);
      rdchk(ADDR_CAUSE, 16'h0000);
    end
  endtask

  task automatic scPin();
    pei_mgmt_master_i.wr(ADDR_MASK, 16'h8080);
    pulse(BIT_LOCK);
    chkIrq(1'b0);
    pei_mgmt_master_i.wr(ADDR_MASK, 16'h0080);
    chkIrq(1'b1);
    rdchk(ADDR_CAUSE, 16'h0080);
    pulse(BIT_LOCK);
    pei_mgmt_master_i.wr(ADDR_MASK, 16'h8080);
    chkIrq(1'b0);
    rdchk(ADDR_CAUSE, 16'h8080);
    chkIrq(1'b1);
    rdchk(ADDR_CAUSE, 16'h0000);
  endtask

  task automatic scLowPower();
    pei_mgmt_master_i.wr(ADDR_MASK, 16'h2000);
    pei_mgmt_master_i.setLowPower();
    rdchk(ADDR_EXT_CTRL, 16'h0020);
    pulse(BIT_LINK);
    rdchk(ADDR_CAUSE, 16'h0000);
    pulse(16);
    rdchk(ADDR_CAUSE, 16'h2000);
    pulse(17);
    rdchk(ADDR_EXT_CTRL, 16'h0000);
    pulse(16);
    rdchk(ADDR_CAUSE, 16'h0000);
  endtask

  // events outside their speed or negotiation mode leave no trace
  task automatic scQualifiers();
    pei_mgmt_master_i.wr(ADDR_MASK, 16'h7ffe);
    evt.anEnabled <= 1'b0;
    pulse(BIT_XOVER);
    evt.anEnabled <= 1'b1;
    evt.speed <= SPD_1000;
    pulse(BIT_JABBER);
    evt.speed <= SPD_10;
    pulse(BIT_MS_ERR);
    pulse(BIT_SYMBOL);
    rdchk(ADDR_CAUSE, 16'h0000);
    evt.speed <= SPD_100;
    pulse(BIT_SYMBOL);
    rdchk(ADDR_CAUSE, 16'h0100);
  endtask

  task automatic scRxErrAndRace();
    pei_word_t d;
    pei_mgmt_master_i.wr(ADDR_MASK, 16'h0000);
    pulse(BIT_RX_ERR);
    rdchk(ADDR_CAUSE, 16'h0001);
    rdchk(ADDR_CAUSE, 16'h0000);
    pei_mgmt_master_i.wr(ADDR_MASK, 16'h8080);
    evt.lockLost <= 1'b1;
    evt.rxErr <= 1'b1;
    fork
      pei_mgmt_master_i.rd(ADDR_CAUSE, d);
      begin
        @(posedge clk_sys);
        evt.lockLost <= 1'b0;
        evt.rxErr <= 1'b0;
      end
    join
    chk(d, 16'h0000);
    rdchk(ADDR_CAUSE, 16'h8081);
  endtask

  task automatic scSticky();
    pei_mgmt_master_i.wr(ADDR_MASK, 16'hffff);
    softReset();
    rdchk(ADDR_MASK, 16'h0000);
    pei_mgmt_master_i.wr(ADDR_AUX_CTRL, 16'h0002);
    rdchk(ADDR_AUX_CTRL, 16'h0002);
    pei_mgmt_master_i.wr(ADDR_MASK, 16'hffff);
    softReset();
    rdchk(ADDR_MASK, 16'h7fff);
  endtask

  // ------------------------------------------------------------
  // clock, reset, sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    $display("unexpected at %0t: run did not finish", $time);
    end_sim();
  end

  initial begin
    fail_count = 0;
    checks = 0;
    srst = 1'b1;
    mgmtSoftRst = 1'b0;
    evt = '0;
    evt.anEnabled = 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    scResetAndMap();
    scGatedEvents();
    scPin();
    scLowPower();
    scQualifiers();
    scRxErrAndRace();
    scSticky();
    end_sim();
  end
endmodule
